/* File: ssfh_regs.svh */
// constants for the serial slave frame handler: codes, lengths and crc values
`ifndef SSFH_REGS_SVH
`define SSFH_REGS_SVH

// ----------------------------------------
// function codes
// ----------------------------------------
`define SSFH_FUNC_READ    8'h03
`define SSFH_FUNC_LOOP    8'h08
`define SSFH_FUNC_WRITE   8'h10
`define SSFH_ERR_FLAG     8'h80

// ----------------------------------------
// error codes carried in an error response
// ----------------------------------------
`define SSFH_ERR_NONE     8'h00
`define SSFH_ERR_FUNC     8'h01
`define SSFH_ERR_LEN      8'h02
`define SSFH_ERR_QTY      8'h03

// ----------------------------------------
// crc and frame figures
// ----------------------------------------
`define SSFH_CRC_PRESET   16'hffff
`define SSFH_CRC_POLY     16'ha001
`define SSFH_ADDR_MAX     8'h1f
`define SSFH_MAX_QTY      16'h0010
`define SSFH_BUF_DEPTH    6'h29
`define SSFH_MIN_FRAME    6'h04
`define SSFH_LEN_FIXED    6'h08
`define SSFH_WR_HDR       6'h09
`define SSFH_RD_HDR       6'h03
`define SSFH_WR_DATA0     6'h07
`define SSFH_ECHO_LEN     6'h06
`define SSFH_ERR_LEN_B    6'h03

`endif

/* File: ssfh_pkg.sv */
// types shared by the serial slave frame handler
package ssfh_pkg;

   // ----------------------------------------
   // controller states, one-hot
   // ----------------------------------------
   typedef enum logic [5:0] {
      SSFH_RECV  = 6'b000001,   // collecting command bytes
      SSFH_CHECK = 6'b000010,   // judging the frame
      SSFH_READ  = 6'b000100,   // fetching registers
      SSFH_WRITE = 6'b001000,   // storing registers
      SSFH_SEND  = 6'b010000,   // emitting response bytes
      SSFH_DRAIN = 6'b100000    // waiting for last byte taken
   } ssfh_state_t;

   typedef logic [7:0] ssfh_byte_t;   // one frame byte

endpackage : ssfh_pkg

/* File: ssfh_frame_handler.sv */
// slave frame handler: receive, check, execute and answer command frames
`timescale 1ns/1ps
`include "ssfh_regs.svh"

// Function
// - answer each accepted command once, never unsolicited
// - accept any slave address 0 to 31
// - read 03: command 8 bytes, reply 7-37
// - loop back 08: command and reply 8 bytes
// - write 10: command 11-41, reply 8 bytes
// - frame: address, function, data, crc
// - check received crc, append crc on transmit
// - preset crc accumulator to ffff
// - xor byte low, eight shifts, poly a001
// - crc bytes in frame order, low first
// - final accumulator is the two-byte checksum
// - read quantity above 16 is refused
// - read returns consecutive registers from start
// - register value sent high byte first
// - error reply: address, function|80, code, crc
// - loop back echoes the frame unchanged
// - write: start, quantity, count, data high first
module ssfh_frame_handler
   import ssfh_pkg::*;
(
   input  wire logic        clk,           // 20 mhz system clock
   input  wire logic        rst_b,         // async reset, active low
   input  wire logic        rx_valid,      // received byte strobe
   input  wire logic [7:0]  rx_data,       // received byte
   input  wire logic        rx_last,       // byte closes the frame
   input  wire logic        tx_ready,      // transmitter takes tx_data
   output logic             tx_valid,      // response byte offered
   output logic [7:0]       tx_data,       // response byte
   output logic             reg_rd,        // register read pulse
   output logic             reg_wr,        // register write pulse
   output logic [15:0]      reg_addr,      // register address
   output logic [15:0]      reg_wdata,     // register write data
   input  wire logic [15:0] reg_rdata,     // read data, cycle after reg_rd
   output logic             crc_err,       // communication error pulse
   output logic             busy           // frame in progress after close
);

   // ----------------------------------------
   // crc step over one byte
   // ----------------------------------------
   function automatic logic [15:0] ssfh_crc_step(input logic [15:0] c,
                                                 input logic [7:0]  b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `SSFH_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : ssfh_crc_step

   // ----------------------------------------
   // state and storage
   // ----------------------------------------
   ssfh_state_t state_q;                 // controller state
   ssfh_byte_t  buf_q [0:40];            // frame buffer, index addressed
   logic [5:0]  cnt_q;                   // received byte count
   logic        ovf_q;                   // frame longer than buffer
   logic [15:0] crc_q;                   // crc accumulator
   logic [5:0]  idx_q;                   // transmit byte index
   logic [5:0]  len_q;                   // response length without crc
   logic [7:0]  err_q;                   // error code, zero when none
   logic        is_rd_q;                 // response is a read reply
   logic [4:0]  wrd_q;                   // register word counter
   logic [1:0]  ph_q;                    // read access phase
   // read data lands on the header slots, so start and quantity are held apart
   logic [15:0] st_q;                    // start address of the command
   logic [5:0]  qty_q;                   // register quantity of the command
   logic        tx_valid_q;              // output flops
   logic [7:0]  tx_data_q;
   logic        reg_rd_q;
   logic        reg_wr_q;
   logic [15:0] reg_addr_q;
   logic [15:0] reg_wdata_q;
   logic        crc_err_q;
   logic        busy_q;

   // ----------------------------------------
   // frame field decode
   // ----------------------------------------
   wire [7:0]  f_addr  = buf_q[0];                    // slave address
   wire [7:0]  f_func  = buf_q[1];                    // function code
   wire [15:0] f_start = {buf_q[2], buf_q[3]};        // start, high first
   wire [15:0] f_qty   = {buf_q[4], buf_q[5]};        // quantity
   wire [7:0]  f_bcnt  = buf_q[6];                    // write byte count
   wire [5:0]  qty6    = f_qty[5:0];                  // small quantity
   wire [5:0]  qty2    = 6'(qty6 << 1);               // twice quantity

   // address range, no own address to compare
   wire addr_ok  = (f_addr <= `SSFH_ADDR_MAX);
   // crc residue is zero when the low-first checksum matches
   wire frame_ok = (crc_q == 16'h0000) && !ovf_q
                   && (cnt_q >= `SSFH_MIN_FRAME);
   // quantity between one and sixteen
   wire qty_ok   = (f_qty != 16'h0000) && (f_qty <= `SSFH_MAX_QTY);

   // ----------------------------------------
   // per-function verdicts
   // ----------------------------------------
   wire is_read  = (f_func == `SSFH_FUNC_READ);
   wire is_loop  = (f_func == `SSFH_FUNC_LOOP);
   wire is_write = (f_func == `SSFH_FUNC_WRITE);

   // read: fixed eight bytes, quantity in range
   wire [7:0] rd_err = (cnt_q != `SSFH_LEN_FIXED) ? `SSFH_ERR_LEN :
                       !qty_ok ? `SSFH_ERR_QTY :
                       `SSFH_ERR_NONE;
   // loop back: fixed eight bytes
   wire [7:0] lb_err = (cnt_q != `SSFH_LEN_FIXED) ? `SSFH_ERR_LEN :
                       `SSFH_ERR_NONE;
   // write: count twice quantity, length header plus data
   wire wr_len_ok = ({2'b00, f_bcnt[5:0]} == {2'b00, qty2})
                    && (f_bcnt[7:6] == 2'b00)
                    && (cnt_q == 6'(`SSFH_WR_HDR + qty2));
   wire [7:0] wr_err = !qty_ok ? `SSFH_ERR_QTY :
                       !wr_len_ok ? `SSFH_ERR_LEN :
                       `SSFH_ERR_NONE;
   // unknown function code
   wire [7:0] chk_err = is_read  ? rd_err :
                        is_loop  ? lb_err :
                        is_write ? wr_err : `SSFH_ERR_FUNC;

   // ----------------------------------------
   // response length and byte selection
   // ----------------------------------------
   wire [5:0] rsp_len = (chk_err != `SSFH_ERR_NONE) ? `SSFH_ERR_LEN_B :
                        is_read ? 6'(`SSFH_RD_HDR + qty2) :
                        `SSFH_ECHO_LEN;

   // error reply: address, flagged function, code
   wire [7:0] err_byte = (idx_q == 6'h00) ? buf_q[0] :
                         (idx_q == 6'h01) ? (buf_q[1] | `SSFH_ERR_FLAG) :
                         err_q;
   // read reply puts the byte count after the function code
   wire [7:0] ok_byte  = (is_rd_q && idx_q == 6'h02) ? {1'b0, qty_q, 1'b0} :
                         buf_q[idx_q];
   wire [7:0] tx_byte  = (err_q != `SSFH_ERR_NONE) ? err_byte : ok_byte;

   // transmitter may take a new byte
   wire       tx_load  = !tx_valid_q || tx_ready;

   // buffer slots for register words
   wire [5:0] rd_slot  = 6'(`SSFH_RD_HDR + {wrd_q, 1'b0});
   wire [5:0] wr_slot  = 6'(`SSFH_WR_DATA0 + {wrd_q, 1'b0});
   wire       last_wrd = ({1'b0, wrd_q} == 6'(qty_q - 6'h01));
   wire [15:0] wrd_addr = 16'(st_q + {11'h000, wrd_q});

   // ----------------------------------------
   // frame buffer
   // ----------------------------------------
   // receive fills from index zero, read phase writes data words
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 41; i++) begin
            buf_q[i] <= 8'h00;
         end
      end else if (state_q == SSFH_RECV && rx_valid && cnt_q < `SSFH_BUF_DEPTH) begin
         buf_q[cnt_q] <= rx_data;
      end else if (state_q == SSFH_READ && ph_q == 2'd2) begin
         buf_q[rd_slot]        <= reg_rdata[15:8];
         buf_q[rd_slot + 6'h1] <= reg_rdata[7:0];
      end
   end

   // ----------------------------------------
   // controller
   // ----------------------------------------
   // one process walks receive, check, execute and send
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q     <= SSFH_RECV;
         cnt_q       <= 6'h00;
         ovf_q       <= 1'b0;
         crc_q       <= `SSFH_CRC_PRESET;
         idx_q       <= 6'h00;
         len_q       <= 6'h00;
         err_q       <= `SSFH_ERR_NONE;
         is_rd_q     <= 1'b0;
         st_q        <= 16'h0000;
         qty_q       <= 6'h00;
         wrd_q       <= 5'h00;
         ph_q        <= 2'd0;
         tx_valid_q  <= 1'b0;
         tx_data_q   <= 8'h00;
         reg_rd_q    <= 1'b0;
         reg_wr_q    <= 1'b0;
         reg_addr_q  <= 16'h0000;
         reg_wdata_q <= 16'h0000;
         crc_err_q   <= 1'b0;
         busy_q      <= 1'b0;
      end else begin
         // pulses default low
         reg_rd_q  <= 1'b0;
         reg_wr_q  <= 1'b0;
         crc_err_q <= 1'b0;
         case (state_q)
            // collect bytes, crc over every byte in arrival order
            SSFH_RECV: begin
               if (rx_valid) begin
                  crc_q <= ssfh_crc_step(crc_q, rx_data);
                  if (cnt_q < `SSFH_BUF_DEPTH) begin
                     cnt_q <= cnt_q + 6'h01;
                  end else begin
                     ovf_q <= 1'b1;                          // too long
                  end
                  if (rx_last) begin
                     state_q <= SSFH_CHECK;
                     busy_q  <= 1'b1;
                  end
               end
            end
            // judge the frame and choose the action
            SSFH_CHECK: begin
               crc_q   <= `SSFH_CRC_PRESET;
               idx_q   <= 6'h00;
               wrd_q   <= 5'h00;
               ph_q    <= 2'd0;
               err_q   <= chk_err;
               len_q   <= rsp_len;
               is_rd_q <= is_read;
               st_q    <= f_start;
               qty_q   <= qty6;
               if (!addr_ok || !frame_ok) begin
                  // silent drop, no reply to a bad frame
                  crc_err_q <= addr_ok;
                  cnt_q     <= 6'h00;
                  ovf_q     <= 1'b0;
                  busy_q    <= 1'b0;
                  state_q   <= SSFH_RECV;
               end else if (chk_err != `SSFH_ERR_NONE) begin
                  state_q <= SSFH_SEND;
               end else if (is_read) begin
                  state_q <= SSFH_READ;
               end else if (is_write) begin
                  state_q <= SSFH_WRITE;
               end else begin
                  state_q <= SSFH_SEND;
               end
            end
            // issue, wait, capture for each word
            SSFH_READ: begin
               case (ph_q)
                  2'd0: begin
                     reg_rd_q   <= 1'b1;
                     reg_addr_q <= wrd_addr;
                     ph_q       <= 2'd1;
                  end
                  2'd1: begin
                     ph_q <= 2'd2;                          // data next cycle
                  end
                  default: begin
                     ph_q  <= 2'd0;
                     wrd_q <= wrd_q + 5'h01;
                     if (last_wrd) begin
                        state_q <= SSFH_SEND;
                     end
                  end
               endcase
            end
            // one write pulse per word, address order
            SSFH_WRITE: begin
               reg_wr_q    <= 1'b1;
               reg_addr_q  <= wrd_addr;
               reg_wdata_q <= {buf_q[wr_slot], buf_q[wr_slot + 6'h1]};
               wrd_q       <= wrd_q + 5'h01;
               if (last_wrd) begin
                  state_q <= SSFH_SEND;
               end
            end
            // body bytes, then crc low, then crc high
            SSFH_SEND: begin
               if (tx_load) begin
                  tx_valid_q <= 1'b1;
                  idx_q      <= idx_q + 6'h01;
                  if (idx_q < len_q) begin
                     tx_data_q <= tx_byte;
                     crc_q     <= ssfh_crc_step(crc_q, tx_byte);
                  end else if (idx_q == len_q) begin
                     tx_data_q <= crc_q[7:0];
                  end else begin
                     tx_data_q <= crc_q[15:8];
                     state_q   <= SSFH_DRAIN;
                  end
               end
            end
            // last byte taken, reopen reception
            SSFH_DRAIN: begin
               if (tx_ready) begin
                  tx_valid_q <= 1'b0;
                  cnt_q      <= 6'h00;
                  ovf_q      <= 1'b0;
                  crc_q      <= `SSFH_CRC_PRESET;
                  busy_q     <= 1'b0;
                  state_q    <= SSFH_RECV;
               end
            end
            default: begin
               state_q <= SSFH_RECV;
            end
         endcase
      end
   end

   // ----------------------------------------
   // outputs straight from flops
   // ----------------------------------------
   assign tx_valid  = tx_valid_q;
   assign tx_data   = tx_data_q;
   assign reg_rd    = reg_rd_q;
   assign reg_wr    = reg_wr_q;
   assign reg_addr  = reg_addr_q;
   assign reg_wdata = reg_wdata_q;
   assign crc_err   = crc_err_q;
   assign busy      = busy_q;

endmodule : ssfh_frame_handler

/* File: ssfh_props.sv */
// port assertions for the slave frame handler
`timescale 1ns/1ps
module ssfh_props
   import ssfh_pkg::*;
(
   input wire logic        clk,       // system clock
   input wire logic        rst_b,     // async reset, active low
   input wire logic        rx_valid,  // byte strobe in
   input wire logic        rx_last,   // frame close in
   input wire logic        tx_ready,  // transmitter ready in
   input wire logic        tx_valid,  // byte offered out
   input wire logic [7:0]  tx_data,   // byte out
   input wire logic        reg_rd,    // register read pulse
   input wire logic        reg_wr,    // register write pulse
   input wire logic [15:0] reg_addr,  // register address
   input wire logic        crc_err,   // communication error pulse
   input wire logic        busy       // frame in progress
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // sequences
   // ----------------------------------------
   sequence s_close;
      rx_valid && rx_last && !busy;
   endsequence
   sequence s_rd_pair;
      reg_rd ##3 reg_rd;
   endsequence
   sequence s_wr_pair;
      reg_wr ##1 reg_wr;
   endsequence
   // ----------------------------------------
   // properties
   // ----------------------------------------
   AST_CLOSE_BUSY: assert property (s_close |=> busy && !tx_valid)
      else $error("busy not raised at frame close");
   AST_NO_UNSOL: assert property (tx_valid |-> busy)
      else $error("byte offered outside a frame");
   AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("offered byte changed while stalled");
   AST_ERR_TIMING: assert property (crc_err |-> $past(rx_valid && rx_last, 2))
      else $error("error pulse not two cycles after close");
   AST_ERR_SILENT: assert property (crc_err |-> !tx_valid [*4])
      else $error("reply after a failed check");
   AST_RD_SPACING: assert property (reg_rd |=> !reg_rd [*2])
      else $error("reads closer than three cycles");
   AST_RD_NEXT: assert property (s_rd_pair |-> reg_addr == $past(reg_addr, 3) + 16'h0001)
      else $error("read address not consecutive");
   AST_WR_NEXT: assert property (s_wr_pair |-> reg_addr == $past(reg_addr) + 16'h0001)
      else $error("write address not consecutive");
   AST_ACCESS_BUSY: assert property (reg_rd || reg_wr |-> busy && !tx_valid)
      else $error("register access outside command");
endmodule : ssfh_props

bind ssfh_frame_handler ssfh_props u_props (.clk(clk), .rst_b(rst_b), .rx_valid(rx_valid),
   .rx_last(rx_last), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
   .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .crc_err(crc_err), .busy(busy));

/* File: ssfh_reg_model.sv */
// register bank model that answers the handler's register port
`timescale 1ns/1ps
module ssfh_reg_model
   import ssfh_pkg::*;
(
   input  wire logic        clk,        // system clock
   input  wire logic        reg_rd,     // read pulse
   input  wire logic        reg_wr,     // write pulse
   input  wire logic [15:0] reg_addr,   // address
   input  wire logic [15:0] reg_wdata,  // write data
   output logic      [15:0] reg_rdata   // read data, cycle after pulse
);
   logic [15:0] mem [0:63];  // register contents, low address bits only
   // fill with a pattern the bench can predict
   initial begin
      for (int i = 0; i < 64; i++) mem[i] = 16'ha500 ^ 16'(i);
      reg_rdata = 16'h0000;
   end
   // data valid one cycle after the pulse, inverted otherwise so stale use shows
   always @(posedge clk) begin
      if (reg_rd) reg_rdata <= mem[reg_addr[5:0]];
      else reg_rdata <= ~reg_rdata;
      if (reg_wr) mem[reg_addr[5:0]] <= reg_wdata;
   end
endmodule : ssfh_reg_model

/* File: testbench.sv */
// self-checking bench for the slave frame handler
`timescale 1ns/1ps
`include "ssfh_regs.svh"
module testbench
   import ssfh_pkg::*;
;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic        clk = 1'b0;   // system clock
   logic        rst_b;        // reset, active low
   logic        rx_valid;     // byte strobe
   ssfh_byte_t  rx_data;      // byte in
   logic        rx_last;      // frame close
   logic        tx_ready;     // transmitter ready
   wire         tx_valid, reg_rd, reg_wr, crc_err, busy;
   wire  [7:0]  tx_data;
   wire  [15:0] reg_addr, reg_wdata, reg_rdata;
   int          n_fail = 0, comparisons = 0, n_crc = 0;
   ssfh_byte_t  got[$], none[$];
   always #25 clk = ~clk;
   ssfh_frame_handler dut (.clk(clk), .rst_b(rst_b), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_last(rx_last), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
      .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .crc_err(crc_err), .busy(busy));
   ssfh_reg_model u_regs (.clk(clk), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   // count error pulses
   always @(posedge clk) if (crc_err === 1'b1) n_crc <= n_crc + 1;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] crc16(input ssfh_byte_t q[$]);
      logic [15:0] c;
      c = `SSFH_CRC_PRESET;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ `SSFH_CRC_POLY : c >> 1;
      end
      return c;
   endfunction : crc16
   task automatic add_crc(inout ssfh_byte_t q[$]);
      logic [15:0] c;
      c = crc16(q);
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
   endtask : add_crc
   task automatic cmp8(input ssfh_byte_t g, input ssfh_byte_t e);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp8
   task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp16
   // send a frame, then take the reply with periodic stalls until busy drops
   task automatic run(input string name, input ssfh_byte_t c[$], input ssfh_byte_t r[$]);
      for (int k = 0; k < 400 && busy !== 1'b0; k++) @(posedge clk);
      foreach (c[i]) begin
         @(posedge clk);
         rx_valid <= 1'b1;
         rx_data  <= c[i];
         rx_last  <= (i == c.size() - 1);
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_last  <= 1'b0;
      got = {};
      for (int k = 0; k < 400; k++) begin
         @(posedge clk);
         if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_data);
         tx_ready <= (k % 3 != 1);
         if (k > 2 && busy === 1'b0) break;
      end
      cmp8({7'h00, busy}, 8'h00);
      cmp8(8'(got.size()), 8'(r.size()));
      foreach (r[i]) if (i < got.size()) cmp8(got[i], r[i]);
      $display("test %s done", name);
   endtask : run
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_loop();
      ssfh_byte_t c[$];
      c = {8'h01, 8'h08, 8'h00, 8'h00, 8'ha5, 8'h37};
      add_crc(c);
      cmp8(c[6], 8'hda);
      cmp8(c[7], 8'h8d);
      run("loop", c, c);
   endtask : t_loop
   task automatic t_read();
      ssfh_byte_t c[$], r[$];
      c = {8'h1f, 8'h03, 8'h00, 8'h1f, 8'h00, 8'h02};
      r = {8'h1f, 8'h03, 8'h04, 8'ha5, 8'h1f, 8'ha5, 8'h20};
      add_crc(c);
      add_crc(r);
      run("read", c, r);
   endtask : t_read
   task automatic t_err(input ssfh_byte_t a, input ssfh_byte_t f, input ssfh_byte_t q,
                        input ssfh_byte_t code);
      ssfh_byte_t c[$], r[$];
      c = {a, f, 8'h00, 8'h20, 8'h00, q};
      r = {a, f | `SSFH_ERR_FLAG, code};
      add_crc(c);
      add_crc(r);
      run("error", c, r);
   endtask : t_err
   task automatic t_write();
      ssfh_byte_t c[$], r[$];
      c = {8'h01, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h02, 8'h58};
      r = c[0:5];
      add_crc(c);
      add_crc(r);
      cmp8(c[11], 8'h63);
      cmp8(c[12], 8'h39);
      cmp8(r[6], 8'h10);
      cmp8(r[7], 8'h08);
      run("write", c, r);
      cmp16(u_regs.mem[1], 16'h0001);
      cmp16(u_regs.mem[2], 16'h0258);
   endtask : t_write
   task automatic t_drop(input ssfh_byte_t a, input logic flip, input int errs);
      ssfh_byte_t c[$];
      int n0;
      c = {a, 8'h08, 8'h00, 8'h00, 8'ha5, 8'h37};
      add_crc(c);
      c[7] = c[7] ^ {7'h00, flip};
      n0 = n_crc;
      run("drop", c, none);
      cmp8(8'(n_crc - n0), 8'(errs));
   endtask : t_drop
   // reset in mid-frame drops the partial frame and quiets the pulse, busy and transmit outputs
   task automatic t_reset();
      ssfh_byte_t c[$];
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= 8'h01;
      repeat (3) @(posedge clk);
      rx_valid <= 1'b0;
      rst_b    <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      cmp16({3'h0, reg_rd, reg_wr, crc_err, busy, tx_valid, tx_data}, 16'h0000);
      c = {8'h01, 8'h08, 8'h00, 8'h00, 8'ha5, 8'h37};
      add_crc(c);
      run("reset", c, c);
   endtask : t_reset
   // ----------------------------------------
   // closing and main sequence
   // ----------------------------------------
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test
   initial begin
      rst_b    = 1'b0;
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      rx_last  = 1'b0;
      tx_ready = 1'b1;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      cmp16({3'h0, reg_rd, reg_wr, crc_err, busy, tx_valid, tx_data}, 16'h0000);
      t_loop();
      t_read();
      t_err(8'h02, `SSFH_FUNC_READ, 8'h11, `SSFH_ERR_QTY);
      t_err(8'h00, 8'h04, 8'h01, `SSFH_ERR_FUNC);
      t_write();
      t_drop(8'h01, 1'b1, 1);
      t_drop(8'h20, 1'b0, 0);
      t_reset();
      stop_test();
   end
   // watchdog well past the few hundred cycles the tests need
   initial begin
      #1000000;
      n_fail++;
      stop_test();
   end
endmodule : testbench
